// ===== hdl/hcw_regs.svh
// Register offsets, field positions, reset values and timing counts
// Assumes byte offsets within a 256-byte configuration space
`ifndef HCW_REGS_SVH
`define HCW_REGS_SVH

// Byte offsets
`define HCW_OFS_BOARD_ID      8'h2E
`define HCW_OFS_CAP_HEAD      8'h34
`define HCW_OFS_HUB_CFG       8'h50

// Read-only contents
`define HCW_CAP_HEAD_VAL      8'h88

// Hub configuration fields
`define HCW_CFG_GWE           7
`define HCW_CFG_DLS           6
`define HCW_CFG_LOCALMEM_FREQ_SELECT          4
`define HCW_CFG_PCP           3
`define HCW_CFG_SYSMEM_FREQ_SELECT          2
`define HCW_CFG_WR_MASK       8'hC8
`define HCW_CFG_RST           8'h40

// Timing counts in packets and clocks
`define HCW_H2G_PKT_LIMIT     3'h6
`define HCW_WINDOW_CLKS       5'h18
`define HCW_SNOOP_STALL_CLKS  5'h1F

`endif

// ===== hdl/hcw_pkg.sv
// Types shared by the hub configuration window and its arbiter
// Assumes hcw_regs.svh is on the include path
`default_nettype none
package hcw_pkg;
    typedef enum logic [2:0] {
        HCW_S2_IDLE = 3'h1,
        HCW_S2_HOST = 3'h2,
        HCW_S2_GFX  = 3'h4
    } hcw_s2_state_type;
    typedef enum logic [2:0] {
        HCW_S1_IDLE  = 3'h1,
        HCW_S1_H2G   = 3'h2,
        HCW_S1_OTHER = 3'h4
    } hcw_s1_state_type;
endpackage
`default_nettype wire

// ===== hdl/hcw_arb_if.sv
// Signals between the configuration window and the memory arbiter
// Assumes one clock shared by both ends
`default_nettype none
interface hcw_arb_if;
    logic windowEn;
    logic h2gReq;
    logic otherReq;
    logic pktDone;
    logic h2gGnt;
    logic otherGnt;
    logic hostReq;
    logic gfxReq;
    logic hostGnt;
    logic gfxGnt;
    modport cfg (
        output windowEn, h2gReq, otherReq, pktDone, hostReq, gfxReq,
        input  h2gGnt, otherGnt, hostGnt, gfxGnt
    );
    modport arb (
        input  windowEn, h2gReq, otherReq, pktDone, hostReq, gfxReq,
        output h2gGnt, otherGnt, hostGnt, gfxGnt
    );
endinterface
`default_nettype wire

// ===== hdl/hcw_arbiter.sv
// Two-stage system memory arbiter: packet stage and time-window stage
// Assumes requests are synchronous to clk and held until granted
`include "hcw_regs.svh"
`default_nettype none
module hcw_arbiter (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Arbiter signals
    hcw_arb_if.arb    arb
);
    import hcw_pkg::*;

    ////////////////////////////////////////////////////////////////////
    hcw_s1_state_type s1State_r;
    logic [2:0]       h2gRun_r;
    logic             h2gWins;
    hcw_s2_state_type s2State_r;
    logic [4:0]       s2Cnt_r;
    logic             s2Win_r;
    assign h2gWins = arb.h2gReq && !(arb.windowEn && arb.otherReq &&
                     h2gRun_r == `HCW_H2G_PKT_LIMIT);

    // Stage 1: packets held until pktDone
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1State_r <= HCW_S1_IDLE;
        end else begin
            case (s1State_r)
                HCW_S1_IDLE: begin
                    if (h2gWins) begin
                        s1State_r <= HCW_S1_H2G;
                    end else if (arb.otherReq) begin
                        s1State_r <= HCW_S1_OTHER;
                    end
                end
                HCW_S1_H2G, HCW_S1_OTHER: begin
                    if (arb.pktDone) begin
                        s1State_r <= HCW_S1_IDLE;
                    end
                end
                default: s1State_r <= HCW_S1_IDLE;
            endcase
        end
    end

    // Consecutive host-to-graphics packet count
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            h2gRun_r <= 3'h0;
        end else if (s1State_r == HCW_S1_IDLE) begin
            if (h2gWins) begin
                if (h2gRun_r != `HCW_H2G_PKT_LIMIT) begin
                    h2gRun_r <= h2gRun_r + 3'h1;
                end
            end else if (arb.otherReq) begin
                h2gRun_r <= 3'h0;
            end
        end
    end

    assign arb.h2gGnt   = (s1State_r == HCW_S1_H2G);
    assign arb.otherGnt = (s1State_r == HCW_S1_OTHER);

    ////////////////////////////////////////////////////////////////////
    // Stage 2: host versus low-priority graphics, 24-clock windows
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s2State_r <= HCW_S2_IDLE;
            s2Win_r   <= 1'b0;
        end else begin
            case (s2State_r)
                HCW_S2_IDLE: begin
                    s2Win_r <= arb.windowEn;
                    if (arb.hostReq) begin
                        s2State_r <= HCW_S2_HOST;
                    end else if (arb.gfxReq) begin
                        s2State_r <= HCW_S2_GFX;
                    end
                end
                HCW_S2_HOST: begin
                    if (!arb.hostReq) begin
                        s2State_r <= HCW_S2_IDLE;
                    end else if (s2Win_r && arb.gfxReq &&
                                 s2Cnt_r == `HCW_WINDOW_CLKS - 5'h1) begin
                        s2State_r <= HCW_S2_GFX;
                    end
                end
                HCW_S2_GFX: begin
                    // Fixed mode never preempts a running grant
                    if (!arb.gfxReq) begin
                        s2State_r <= HCW_S2_IDLE;
                    end else if (s2Win_r && arb.hostReq &&
                                 s2Cnt_r == `HCW_WINDOW_CLKS - 5'h1) begin
                        s2State_r <= HCW_S2_HOST;
                    end
                end
                default: s2State_r <= HCW_S2_IDLE;
            endcase
        end
    end

    // Window length counter
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s2Cnt_r <= 5'h0;
        end else if (s2State_r == HCW_S2_IDLE ||
                     s2Cnt_r == `HCW_WINDOW_CLKS - 5'h1) begin
            s2Cnt_r <= 5'h0;
        end else begin
            s2Cnt_r <= s2Cnt_r + 5'h1;
        end
    end

    assign arb.hostGnt = (s2State_r == HCW_S2_HOST);
    assign arb.gfxGnt  = (s2State_r == HCW_S2_GFX);
endmodule
`default_nettype wire

// ===== hdl/hcw_config_window.sv
// Hub configuration window: board identity, capability head, hub config
// Assumes config accesses are synchronous to clk; pins are asynchronous
`include "hcw_regs.svh"
`default_nettype none
module hcw_config_window #(
    // Arbitrary cleared value of the board identity
    parameter logic [15:0] SID_RESET = 16'h5A5A
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Configuration access, dword address with byte enables
    input  wire logic [7:2]  cfgAddr,
    input  wire logic [3:0]  cfgByteEn,
    input  wire logic        cfgWrite,
    input  wire logic        cfgRead,
    input  wire logic [31:0] cfgWrData,
    output logic      [31:0] cfgRdData,
    output logic             cfgRdValid,
    // Strap and mode pins
    input  wire logic        sysmemFreqStrap,
    input  wire logic        localmemFreqStrap,
    input  wire logic        graphicsMode,
    // Processor deferral
    input  wire logic        address_strobe_in_n,
    input  wire logic        deferrablePending,
    input  wire logic        snoopStall,
    output logic             deferNow,
    // Page control
    input  wire logic        pageMiss,
    input  wire logic        rowChange,
    input  wire logic        refreshReq,
    input  wire logic [1:0]  missBank,
    output logic             prechargeAll,
    output logic             prechargeBank,
    output logic      [1:0]  prechargeBankSel,
    // Memory arbiter requests and grants
    input  wire logic        h2gReq,
    input  wire logic        otherReq,
    input  wire logic        pktDone,
    input  wire logic        hostReq,
    input  wire logic        gfxReq,
    output logic             h2gGnt,
    output logic             otherGnt,
    output logic             hostGnt,
    output logic             gfxGnt,
    // Selected frequencies
    output logic             sysmemFreqSelect,
    output logic             localmemFreqSelect
);
    import hcw_pkg::*;

    // Byte lane of an offset is hit when its dword matches and lane enabled
    function automatic logic laneHit(input logic [7:0] ofs,
                                     input logic [7:2] addr,
                                     input logic [3:0] be);
        laneHit = (addr == ofs[7:2]) && be[ofs[1:0]];
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers, no reset so straps track during reset
    logic [1:0] smStrapSync;
    logic [1:0] lmStrapSync;
    logic [1:0] gfxModeSync;
    logic [1:0] strobeSync;
    always_ff @(posedge clk) begin
        smStrapSync <= {smStrapSync[0], sysmemFreqStrap};
        lmStrapSync <= {lmStrapSync[0], localmemFreqStrap};
        gfxModeSync <= {gfxModeSync[0], graphicsMode};
        strobeSync  <= {strobeSync[0], address_strobe_in_n};
    end

    ////////////////////////////////////////////////////////////////////
    // Board identity, write-once per byte pair
    logic [15:0] board_identity_reg_r;
    logic        boardIdLocked_r;
    logic [1:0]  sidHit;

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gSid
            assign sidHit[g] = cfgWrite && !boardIdLocked_r &&
                laneHit(`HCW_OFS_BOARD_ID + 8'(g), cfgAddr, cfgByteEn);
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    board_identity_reg_r[g*8 +: 8] <= SID_RESET[g*8 +: 8];
                end else if (sidHit[g]) begin
                    board_identity_reg_r[g*8 +: 8] <=
                        cfgWrData[(g+2)*8 +: 8];
                end
            end
        end
    endgenerate

    // Any write touching the register closes it until reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            boardIdLocked_r <= 1'b0;
        end else if (|sidHit) begin
            boardIdLocked_r <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Hub configuration register
    logic [7:0] hub_config_reg_r;
    logic       strapTaken_r;
    logic       cfgHit;
    assign cfgHit = cfgWrite &&
        laneHit(`HCW_OFS_HUB_CFG, cfgAddr, cfgByteEn);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hub_config_reg_r <= `HCW_CFG_RST;
            strapTaken_r     <= 1'b0;
        end else begin
            strapTaken_r <= 1'b1;
            if (!strapTaken_r) begin
                // Straps caught on the first edge after release
                hub_config_reg_r[`HCW_CFG_SYSMEM_FREQ_SELECT] <= smStrapSync[1];
                hub_config_reg_r[`HCW_CFG_LOCALMEM_FREQ_SELECT] <= lmStrapSync[1];
            end else if (cfgHit) begin
                hub_config_reg_r <=
                    (hub_config_reg_r & ~`HCW_CFG_WR_MASK) |
                    (cfgWrData[7:0] & `HCW_CFG_WR_MASK);
                if (!gfxModeSync[1]) begin
                    hub_config_reg_r[`HCW_CFG_SYSMEM_FREQ_SELECT] <=
                        cfgWrData[`HCW_CFG_SYSMEM_FREQ_SELECT];
                end
            end
        end
    end

    // Graphics mode forces the system memory select to 100 MHz
    logic [7:0] hubCfgView;
    always_comb begin
        hubCfgView = hub_config_reg_r;
        if (gfxModeSync[1]) begin
            hubCfgView[`HCW_CFG_SYSMEM_FREQ_SELECT] = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sysmemFreqSelect   <= 1'b0;
            localmemFreqSelect <= 1'b0;
        end else begin
            sysmemFreqSelect   <= hubCfgView[`HCW_CFG_SYSMEM_FREQ_SELECT];
            localmemFreqSelect <= hubCfgView[`HCW_CFG_LOCALMEM_FREQ_SELECT];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read path, one clock after the read strobe
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cfgRdData  <= 32'h0000_0000;
            cfgRdValid <= 1'b0;
        end else begin
            cfgRdValid <= cfgRead;
            cfgRdData  <= 32'h0000_0000;
            if (cfgRead) begin
                case (cfgAddr)
                    6'(`HCW_OFS_BOARD_ID >> 2):
                        cfgRdData[31:16] <= board_identity_reg_r;
                    6'(`HCW_OFS_CAP_HEAD >> 2):
                        cfgRdData[7:0] <= `HCW_CAP_HEAD_VAL;
                    6'(`HCW_OFS_HUB_CFG >> 2):
                        cfgRdData[7:0] <= hubCfgView;
                    default: cfgRdData <= 32'h0000_0000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Processor cycle deferral
    logic       strobePrev_r;
    logic [4:0] stallCnt_r;
    logic       strobeFall;
    assign strobeFall = strobePrev_r && !strobeSync[1];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            strobePrev_r <= 1'b1;
            stallCnt_r   <= 5'h0;
            deferNow     <= 1'b0;
        end else begin
            strobePrev_r <= strobeSync[1];
            if (!deferrablePending || deferNow) begin
                stallCnt_r <= 5'h0;
            end else if (snoopStall &&
                         stallCnt_r != `HCW_SNOOP_STALL_CLKS) begin
                stallCnt_r <= stallCnt_r + 5'h1;
            end
            deferNow <= deferrablePending && strobeFall && !deferNow &&
                (!hub_config_reg_r[`HCW_CFG_DLS] ||
                 stallCnt_r == `HCW_SNOOP_STALL_CLKS);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Page closing
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prechargeAll     <= 1'b0;
            prechargeBank    <= 1'b0;
            prechargeBankSel <= 2'h0;
        end else begin
            prechargeAll <= rowChange || refreshReq ||
                (pageMiss && hub_config_reg_r[`HCW_CFG_PCP]);
            prechargeBank <= pageMiss && !rowChange && !refreshReq &&
                !hub_config_reg_r[`HCW_CFG_PCP];
            prechargeBankSel <= missBank;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Memory arbiter
    hcw_arb_if arbBus ();
    assign arbBus.windowEn = hub_config_reg_r[`HCW_CFG_GWE];
    assign arbBus.h2gReq   = h2gReq;
    assign arbBus.otherReq = otherReq;
    assign arbBus.pktDone  = pktDone;
    assign arbBus.hostReq  = hostReq;
    assign arbBus.gfxReq   = gfxReq;
    assign h2gGnt   = arbBus.h2gGnt;
    assign otherGnt = arbBus.otherGnt;
    assign hostGnt  = arbBus.hostGnt;
    assign gfxGnt   = arbBus.gfxGnt;

    hcw_arbiter uArbiter (
        .clk   (clk),
        .rst_n (rst_n),
        .arb   (arbBus.arb)
    );
endmodule
`default_nettype wire

// ===== test/hcw_window_assertions.sv
// Checker for the hub configuration window, bound to its top ports
// Assumes one clock, a synchronous active-low reset and no config
// read in the same cycle as a write
`default_nettype none
module hcw_window_assertions #(
    parameter logic [15:0] SID_RESET = 16'h5A5A
) (
    // Clock, reset and config access
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic [7:2]  cfgAddr,
    input wire logic [3:0]  cfgByteEn,
    input wire logic        cfgWrite,
    input wire logic        cfgRead,
    input wire logic [31:0] cfgWrData,
    input wire logic [31:0] cfgRdData,
    input wire logic        cfgRdValid,
    // Mode, page control and frequency
    input wire logic        graphicsMode,
    input wire logic        pageMiss,
    input wire logic        rowChange,
    input wire logic        refreshReq,
    input wire logic [1:0]  missBank,
    input wire logic        prechargeAll,
    input wire logic        prechargeBank,
    input wire logic [1:0]  prechargeBankSel,
    input wire logic        sysmemFreqSelect,
    // Arbiter
    input wire logic        otherReq,
    input wire logic        hostReq,
    input wire logic        gfxReq,
    input wire logic        h2gGnt,
    input wire logic        otherGnt,
    input wire logic        hostGnt,
    input wire logic        gfxGnt
);
    logic        winMode_r, pagePol_r, winLat_r, sidLock_r;
    logic [15:0] sidVal_r;
    logic [3:0]  h2gRun_r;
    logic [5:0]  holdRun_r;
    //////////////////////////////////////////////////////////////
    // Mirror of the GWE (bit 7) and PCP (bit 3) mode bits
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            winMode_r <= 1'b0;
            pagePol_r <= 1'b0;
        end else if (cfgWrite && cfgAddr == 6'h14 && cfgByteEn[0]) begin
            winMode_r <= cfgWrData[7];
            pagePol_r <= cfgWrData[3];
        end
    end
    // Mode as the idle arbiter latched it
    always_ff @(posedge clk) begin
        if (!rst_n) winLat_r <= 1'b0;
        else if (!hostGnt && !gfxGnt) winLat_r <= winMode_r;
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sidLock_r <= 1'b0;
            sidVal_r  <= SID_RESET;
        end else if (cfgWrite && cfgAddr == 6'h0B && !sidLock_r
                     && (cfgByteEn[2] || cfgByteEn[3])) begin
            sidLock_r <= 1'b1;
            if (cfgByteEn[2]) sidVal_r[7:0] <= cfgWrData[23:16];
            if (cfgByteEn[3]) sidVal_r[15:8] <= cfgWrData[31:24];
        end
    end
    // Never above the real h2g run
    always_ff @(posedge clk) begin
        if (!rst_n || otherGnt || !otherReq) h2gRun_r <= 4'h0;
        else if ($rose(h2gGnt)) h2gRun_r <= h2gRun_r + 4'h1;
    end
    always_ff @(posedge clk) begin
        if (!rst_n || $changed(hostGnt)
            || !(hostGnt && gfxReq || gfxGnt && hostReq))
            holdRun_r <= 6'h00;
        else if (holdRun_r != 6'h3F) holdRun_r <= holdRun_r + 6'h01;
    end
    //////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_rd(a);
        cfgRead && !cfgWrite && cfgAddr == a;
    endsequence
    sequence s_gfx;
        graphicsMode [*5];
    endsequence
    a_read_answer: assert property (cfgRdValid == $past(cfgRead))
        else $error("read valid late");
    a_cap_fixed: assert property (
        s_rd(6'h0B + 6'h02) |=> cfgRdData[7:0] == 8'h88)
        else $error("capability head is not 88h");
    a_id_once: assert property (
        s_rd(6'h0B) |=> cfgRdData[31:16] == sidVal_r)
        else $error("board identity wrong");
    a_host_first: assert property (
        !winMode_r && hostReq && !hostGnt && !gfxGnt |=> hostGnt)
        else $error("host not first");
    a_fixed_hold: assert property (
        !winLat_r && hostGnt && hostReq |=> hostGnt)
        else $error("host grant cut");
    a_h2g_six: assert property (
        winMode_r |-> h2gRun_r <= 4'h6)
        else $error("over six h2g packets");
    a_slice_cap: assert property (
        winLat_r |-> holdRun_r <= 6'h19)
        else $error("holder did not yield");
    a_grant_excl: assert property (
        !(hostGnt && gfxGnt) && !(h2gGnt && otherGnt))
        else $error("two grants at once");
    a_page_bank: assert property (
        pageMiss && !rowChange && !refreshReq && !pagePol_r |=>
        prechargeBank && !prechargeAll && prechargeBankSel == $past(missBank))
        else $error("bank precharge missing");
    a_page_all: assert property (
        rowChange || refreshReq || pageMiss && pagePol_r |=>
        prechargeAll && !prechargeBank)
        else $error("precharge all missing");
    a_gfx_freq: assert property (
        s_gfx |-> !sysmemFreqSelect)
        else $error("sysmem frequency not 0");
endmodule

bind hcw_config_window hcw_window_assertions #(.SID_RESET(SID_RESET))
    hcw_window_assertions_i (
    .clk(clk), .rst_n(rst_n), .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn),
    .cfgWrite(cfgWrite), .cfgRead(cfgRead), .cfgWrData(cfgWrData),
    .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid),
    .graphicsMode(graphicsMode), .pageMiss(pageMiss),
    .rowChange(rowChange), .refreshReq(refreshReq), .missBank(missBank),
    .prechargeAll(prechargeAll), .prechargeBank(prechargeBank),
    .prechargeBankSel(prechargeBankSel),
    .sysmemFreqSelect(sysmemFreqSelect), .otherReq(otherReq),
    .hostReq(hostReq), .gfxReq(gfxReq), .h2gGnt(h2gGnt),
    .otherGnt(otherGnt), .hostGnt(hostGnt), .gfxGnt(gfxGnt)
);
`default_nettype wire

// ===== test/tb_hub_config_and_arbiter_window.sv
// Self-checking bench for the hub configuration window
// Assumes the checker is bound in from its own file
`default_nettype none
module tb_hub_config_and_arbiter_window;
    timeunit 1ns;
    timeprecision 1ps;
    // Arbitrary cleared value of the board identity
    localparam logic [15:0] SID_RST = 16'hC3A5;
    logic        clk, rst_n, cfgWrite, cfgRead, cfgRdValid;
    logic [7:2]  cfgAddr;
    logic [3:0]  cfgByteEn;
    logic [31:0] cfgWrData, cfgRdData;
    logic        sysStrap, lmStrap, graphicsMode, strobeN, pending, stall;
    logic        deferNow, pageMiss, rowChange, refreshReq, pAll, pBank;
    logic [1:0]  missBank, bankSel;
    logic        h2gReq, otherReq, pktDone, hostReq, gfxReq, smSel, lmSel;
    logic        h2gGnt, otherGnt, hostGnt, gfxGnt;
    int          err_total, compares;
    hcw_config_window #(.SID_RESET(SID_RST)) hcw_config_window_i (
        .clk(clk), .rst_n(rst_n), .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn),
        .cfgWrite(cfgWrite), .cfgRead(cfgRead), .cfgWrData(cfgWrData),
        .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid),
        .sysmemFreqStrap(sysStrap), .localmemFreqStrap(lmStrap),
        .graphicsMode(graphicsMode), .address_strobe_in_n(strobeN),
        .deferrablePending(pending), .snoopStall(stall), .deferNow(deferNow),
        .pageMiss(pageMiss), .rowChange(rowChange), .refreshReq(refreshReq),
        .missBank(missBank), .prechargeAll(pAll), .prechargeBank(pBank),
        .prechargeBankSel(bankSel), .h2gReq(h2gReq), .otherReq(otherReq),
        .pktDone(pktDone), .hostReq(hostReq), .gfxReq(gfxReq),
        .h2gGnt(h2gGnt), .otherGnt(otherGnt), .hostGnt(hostGnt),
        .gfxGnt(gfxGnt), .sysmemFreqSelect(smSel), .localmemFreqSelect(lmSel)
    );
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    //////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("compares %0d, mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: got %h, want %h", $time, got, exp);
        end
    endtask
    task automatic do_reset();
        @(posedge clk) rst_n <= 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
    endtask
    task automatic wr(input logic [7:2] a, input logic [3:0] be,
                      input logic [31:0] d);
        @(posedge clk);
        {cfgAddr, cfgByteEn, cfgWrData, cfgWrite} <= {a, be, d, 1'b1};
        @(posedge clk) cfgWrite <= 1'b0;
    endtask
    task automatic rd(input logic [7:2] a, input logic [31:0] m, e);
        @(posedge clk);
        {cfgAddr, cfgRead} <= {a, 1'b1};
        @(posedge clk) cfgRead <= 1'b0;
        @(negedge clk);
        chk(cfgRdValid, 1'b1);
        chk(cfgRdData & m, e);
    endtask
    // Waits out one idle cycle so a slow grant release is not seen twice
    task automatic pkt(input int n, output int h, output int o);
        int k;
        {h, o} = '0;
        repeat (n) begin
            k = 0;
            do begin
                @(negedge clk);
                k++;
            end while (h2gGnt !== 1'b1 && otherGnt !== 1'b1 && k < 10);
            if (h2gGnt === 1'b1) h++;
            if (otherGnt === 1'b1) o++;
            @(posedge clk) pktDone <= 1'b1;
            @(posedge clk) pktDone <= 1'b0;
            @(posedge clk);
        end
    endtask
    task automatic runlen(input logic h, output int n);
        n = 0;
        for (int k = 0; k < 80; k++) begin
            if ((h ? hostGnt : gfxGnt) === 1'b1) n++;
            else if (n > 0) break;
            @(negedge clk);
        end
    endtask
    task automatic dfr(input logic [31:0] e);
        int n = 0;
        @(posedge clk) strobeN <= 1'b0;
        repeat (2) @(posedge clk);
        strobeN <= 1'b1;
        repeat (12) begin
            @(negedge clk);
            if (deferNow === 1'b1) n++;
        end
        chk(n, e);
    endtask
    task automatic pg(input logic m, r, f, input logic [1:0] b,
                      input logic [3:0] e);
        @(posedge clk);
        {pageMiss, rowChange, refreshReq, missBank} <= {m, r, f, b};
        @(posedge clk) {pageMiss, rowChange, refreshReq} <= 3'b000;
        @(negedge clk);
        chk({pAll, pBank, bankSel}, e);
    endtask
    //////////////////////////////////////////////////////////////
    task automatic t_reset();
        rd(6'h14, 32'hFF, 32'h44);
        rd(6'h0D, 32'hFF, 32'h88);
        rd(6'h0B, 32'hFFFF0000, {SID_RST, 16'h0000});
        rd(6'h3F, 32'hFFFFFFFF, 32'h0);
        chk({smSel, lmSel}, 2'b10);
        $display("reset test done");
    endtask
    task automatic t_sid();
        wr(6'h0B, 4'h4, 32'h00AB0000);
        wr(6'h0B, 4'hC, 32'h12340000);
        rd(6'h0B, 32'hFFFF0000, {SID_RST[15:8], 24'hAB0000});
        do_reset();
        rd(6'h0B, 32'hFFFF0000, {SID_RST, 16'h0000});
        wr(6'h0B, 4'hC, 32'h12340000);
        rd(6'h0B, 32'hFFFF0000, 32'h12340000);
        wr(6'h0D, 4'hF, 32'hFFFFFFFF);
        rd(6'h0D, 32'hFF, 32'h88);
        $display("identity test done");
    endtask
    task automatic t_pkt();
        int h, o;
        do_reset();
        wr(6'h14, 4'h1, 32'h80);
        @(posedge clk) {h2gReq, otherReq} <= 2'b11;
        pkt(7, h, o);
        chk(h, 6);
        chk(o, 1);
        wr(6'h14, 4'h1, 32'h00);
        pkt(8, h, o);
        chk(o, 0);
        @(posedge clk) {h2gReq, otherReq} <= 2'b00;
        $display("packet test done");
    endtask
    task automatic t_arb();
        int g = 0, n;
        @(posedge clk) {hostReq, gfxReq} <= 2'b11;
        repeat (6) @(posedge clk);
        wr(6'h14, 4'h1, 32'h80);
        repeat (40) begin
            @(negedge clk);
            if (gfxGnt !== 1'b0) g++;
        end
        chk(g, 0);
        chk(hostGnt, 1'b1);
        @(posedge clk) hostReq <= 1'b0;
        @(negedge clk);
        fork
            runlen(1'b0, n);
            begin
                repeat (4) @(posedge clk);
                hostReq <= 1'b1;
            end
        join
        chk(n, 24);
        runlen(1'b1, n);
        chk(n, 24);
        @(posedge clk) {hostReq, gfxReq} <= 2'b00;
        $display("arbiter test done");
    endtask
    task automatic t_defer();
        wr(6'h14, 4'h1, 32'h00);
        @(posedge clk) pending <= 1'b1;
        dfr(1);
        wr(6'h14, 4'h1, 32'h40);
        dfr(0);
        @(posedge clk) stall <= 1'b1;
        repeat (34) @(posedge clk);
        dfr(1);
        @(posedge clk) {pending, stall} <= 2'b00;
        $display("deferral test done");
    endtask
    task automatic t_page();
        pg(1'b1, 1'b0, 1'b0, 2'h2, 4'b0110);
        pg(1'b1, 1'b0, 1'b0, 2'h1, 4'b0101);
        pg(1'b0, 1'b1, 1'b0, 2'h3, 4'b1011);
        pg(1'b0, 1'b0, 1'b1, 2'h0, 4'b1000);
        wr(6'h14, 4'h1, 32'h08);
        pg(1'b1, 1'b0, 1'b0, 2'h2, 4'b1010);
        $display("page test done");
    endtask
    // Graphics mode last: the strap bit is not re-read on leaving it
    task automatic t_cfg();
        wr(6'h14, 4'h1, 32'hFF);
        rd(6'h14, 32'hFF, 32'hCC);
        @(posedge clk) graphicsMode <= 1'b1;
        repeat (8) @(posedge clk);
        rd(6'h14, 32'hFF, 32'hC8);
        chk(smSel, 1'b0);
        $display("config test done");
    endtask
    //////////////////////////////////////////////////////////////
    initial begin
        {err_total, compares} = '0;
        {rst_n, cfgWrite, cfgRead, pageMiss, rowChange, refreshReq} = '0;
        {pktDone, h2gReq, otherReq, hostReq, gfxReq, pending, stall} = '0;
        {graphicsMode, lmStrap, sysStrap, strobeN} = 4'b0011;
        {cfgAddr, cfgByteEn, cfgWrData, missBank} = '0;
        do_reset();
        t_reset();
        t_sid();
        t_pkt();
        t_arb();
        t_defer();
        t_page();
        t_cfg();
        conclude();
    end
    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        conclude();
    end
endmodule
`default_nettype wire
